// File: rtl/isc_pkg.sv
// Package: register map, timing constants and types of the interlock state controller
package isc_pkg;
  // Clock
  localparam int unsigned CLK_HZ         = 25000000;
  // Timing figures in their own units
  localparam int unsigned TEACH_WAIT_S   = 10;
  localparam int unsigned TEACH_ABORT_MIN = 5;
  localparam int unsigned INHIBIT_MIN    = 10;
  localparam int unsigned WARN_MIN       = 30;
  localparam int unsigned SLOW_FLASH_HZ  = 1;
  localparam int unsigned FAST_FLASH_HZ  = 3;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned ERR_PULSES     = 5;
  // Derived cycle counts and one-second tick counts
  localparam int unsigned TICK_CYC       = CLK_HZ;
  localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int unsigned FAST_HALF_CYC  = CLK_HZ / (2 * FAST_FLASH_HZ);
  localparam int unsigned TEACH_WAIT_TK  = TEACH_WAIT_S;
  localparam int unsigned ABORT_TK       = TEACH_ABORT_MIN * SEC_PER_MIN;
  localparam int unsigned INHIBIT_TK     = INHIBIT_MIN * SEC_PER_MIN;
  localparam int unsigned WARN_TK        = WARN_MIN * SEC_PER_MIN;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CODE   = 8'h08;
  localparam logic [7:0] ADDR_SENSE  = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_PERM    = 0;
  localparam int unsigned CTRL_REPAIR  = 1;
  localparam int unsigned CTRL_P2LOCK  = 2;
  localparam int unsigned CTRL_GUARDMON = 3;
  localparam int unsigned CTRL_INDIV   = 4;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_001F;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [15:0] CODE_NONE     = 16'h0000;

  typedef enum {
    ISC_RUN,
    ISC_TEACH_SHOW,
    ISC_TEACH_OFFREQ,
    ISC_TEACH_ABORT,
    ISC_TEACH_CONFIRM,
    ISC_INHIBIT,
    ISC_ERROR
  } isc_state_t;

  // Sensed inputs after synchronising
  typedef struct packed {
    logic        actuator_present;
    logic        guard_closed;
    logic        handle_detent;
    logic        solenoid_cmd;
    logic        safety_sense_a;
    logic        safety_sense_b;
    logic        internal_fault;
    logic        fault_warning;
  } isc_sense_t;

  // LED drive
  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } isc_led_t;
endpackage : isc_pkg

// File: rtl/isc_controller.sv
// Interlock state controller: teach-in, lock drive, safety outputs, LEDs, AHB-Lite registers
module isc_controller
  import isc_pkg::*;
(
  input  wire logic        hclk,          // System clock, 25 MHz
  input  wire logic        hresetn,       // Power-up reset, active low
  input  wire logic        hsel,          // AHB slave select
  input  wire logic [31:0] haddr,         // AHB address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB bus ready
  output logic      [31:0] hrdata,        // AHB read data
  output logic             hreadyout,     // AHB slave ready
  output logic             hresp,         // AHB response, always OKAY
  input  wire logic        actuator_pin,  // Actuator in detection range
  input  wire logic [15:0] actuator_code, // Code read from actuator
  input  wire logic        guard_pin,     // Guard closed
  input  wire logic        detent_pin,    // Handle in a detent position
  input  wire logic        solenoid_pin,  // Solenoid command input
  input  wire logic        safety_sense_a,// Safety input channel A
  input  wire logic        safety_sense_b,// Safety input channel B
  input  wire logic        fault_pin,     // Internal error detected
  input  wire logic        warn_pin,      // Non-critical fault warning
  output logic             safe_drive_a,  // Safety output A
  output logic             safe_drive_b,  // Safety output B
  output logic             diag_out,      // Diagnostic output
  output logic             lock_drive,    // Solenoid lock engaged
  output logic             led_green,     // Green LED
  output logic             led_yellow,    // Yellow LED
  output logic             led_red        // Red LED
);

  // Three-stage input synchronisers
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r;
  assign pin_raw = {actuator_pin, guard_pin, detent_pin, solenoid_pin,
                    safety_sense_a, safety_sense_b, fault_pin, warn_pin};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_r[gi]   <= 1'b0;
          s2_r[gi]   <= 1'b0;
          s3_r[gi]   <= 1'b0;
          filt_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            filt_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  isc_sense_t sn;
  assign sn = filt_r;

  // Registers; pairing memory skips reset so a learned code outlives power cycles
  logic [31:0] ctrl_r;
  logic [15:0] code_r         = CODE_NONE;
  logic        code_valid_r   = 1'b0;
  logic        paired_r       = 1'b0;
  logic [15:0] learn_r        = CODE_NONE;
  logic        learn_pend_r   = 1'b0;
  logic        inhibit_pend_r = 1'b0;
  logic        bus_wr_r;
  logic [7:0]  bus_addr_r;

  // Bus: zero wait states, OKAY always
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_r   <= 1'b0;
      bus_addr_r <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        bus_wr_r   <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
        bus_addr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (bus_wr_r && bus_addr_r == ADDR_CTRL) begin
      ctrl_r <= hwdata & CTRL_MASK;
    end
  end

  logic perm_v, repair_v, p2lock_v, guardmon_v, indiv_v;
  assign perm_v     = ctrl_r[CTRL_PERM];
  assign repair_v   = ctrl_r[CTRL_REPAIR];
  assign p2lock_v   = ctrl_r[CTRL_P2LOCK];
  assign guardmon_v = ctrl_r[CTRL_GUARDMON];
  assign indiv_v    = ctrl_r[CTRL_INDIV] | perm_v | repair_v;

  // Prescalers
  logic [24:0] tick_cnt_r;
  logic        tick;
  logic [23:0] slow_cnt_r, fast_cnt_r;
  logic        slow_r, fast_r;
  assign tick = (tick_cnt_r == 25'(TICK_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= '0;
      slow_cnt_r <= '0;
      fast_cnt_r <= '0;
      slow_r     <= 1'b0;
      fast_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 25'd1;
      if (slow_cnt_r == 24'(SLOW_HALF_CYC - 1)) begin
        slow_cnt_r <= '0;
        slow_r     <= ~slow_r;
      end else begin
        slow_cnt_r <= slow_cnt_r + 24'd1;
      end
      if (fast_cnt_r == 24'(FAST_HALF_CYC - 1)) begin
        fast_cnt_r <= '0;
        fast_r     <= ~fast_r;
      end else begin
        fast_cnt_r <= fast_cnt_r + 24'd1;
      end
    end
  end

  // Main sequence
  isc_state_t st_r;
  logic [11:0] sec_r;
  logic        fresh_power_r;
  logic        err_open_seen_r;
  logic [3:0]  pulse_cnt_r;
  logic        slow_d_r;
  logic        slow_rise;
  assign slow_rise = slow_r & ~slow_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r            <= ISC_RUN;
      sec_r           <= '0;
      fresh_power_r   <= 1'b1;
      err_open_seen_r <= 1'b0;
    end else begin
      if (sn.actuator_present) begin
        fresh_power_r <= 1'b0;
      end
      case (st_r)
        ISC_RUN: begin
          sec_r <= '0;
          if (sn.internal_fault) begin
            st_r            <= ISC_ERROR;
            err_open_seen_r <= 1'b0;
          end else if (inhibit_pend_r) begin
            st_r <= ISC_INHIBIT;
          end else if (learn_pend_r && sn.actuator_present) begin
            st_r <= ISC_TEACH_CONFIRM;
          end else if (fresh_power_r && sn.actuator_present && indiv_v
                       && !(perm_v && paired_r)
                       && !(code_valid_r && actuator_code == code_r)) begin
            st_r <= ISC_TEACH_SHOW;
          end
        end
        ISC_TEACH_SHOW: begin
          if (tick) begin
            sec_r <= sec_r + 12'd1;
          end
          if (sec_r == 12'(TEACH_WAIT_TK)) begin
            st_r         <= ISC_TEACH_OFFREQ;
            sec_r        <= '0;
            learn_r      <= actuator_code;
            learn_pend_r <= 1'b1;
          end
        end
        ISC_TEACH_OFFREQ: begin
          if (tick) begin
            sec_r <= sec_r + 12'd1;
          end
          if (sec_r == 12'(ABORT_TK)) begin
            st_r         <= ISC_TEACH_ABORT;
            learn_pend_r <= 1'b0;
          end
        end
        ISC_TEACH_ABORT: begin
          st_r <= ISC_TEACH_ABORT;
        end
        ISC_TEACH_CONFIRM: begin
          learn_pend_r <= 1'b0;
          if (actuator_code == learn_r) begin
            code_r       <= learn_r;
            code_valid_r <= 1'b1;
            paired_r     <= 1'b1;
            if (repair_v && paired_r) begin
              st_r           <= ISC_INHIBIT;
              inhibit_pend_r <= 1'b1;
              sec_r          <= '0;
            end else begin
              st_r <= ISC_RUN;
            end
          end else begin
            st_r <= ISC_RUN;
          end
        end
        ISC_INHIBIT: begin
          if (tick && sec_r != 12'(INHIBIT_TK)) begin
            sec_r <= sec_r + 12'd1;
          end
          if (sec_r == 12'(INHIBIT_TK) && sn.actuator_present) begin
            st_r           <= ISC_RUN;
            inhibit_pend_r <= 1'b0;
          end
        end
        ISC_ERROR: begin
          if (!sn.guard_closed) begin
            err_open_seen_r <= 1'b1;
          end
          if (!sn.internal_fault && err_open_seen_r && sn.guard_closed) begin
            st_r <= ISC_RUN;
          end
        end
        default: st_r <= ISC_RUN;
      endcase
    end
  end

  // Warning timer
  logic [11:0] warn_sec_r;
  logic        warn_trip;
  assign warn_trip = (warn_sec_r == 12'(WARN_TK));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_sec_r <= '0;
    end else if (!sn.fault_warning) begin
      warn_sec_r <= '0;
    end else if (tick && !warn_trip) begin
      warn_sec_r <= warn_sec_r + 12'd1;
    end
  end

  // Red pulse train for the abort code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_d_r    <= 1'b0;
      pulse_cnt_r <= '0;
    end else begin
      slow_d_r <= slow_r;
      if (slow_rise) begin
        pulse_cnt_r <= (pulse_cnt_r == 4'(ERR_PULSES + 1)) ? '0 : pulse_cnt_r + 4'd1;
      end
    end
  end

  // Outputs
  logic locked_v, lock_req_v, safe_v, diag_v, inputs_ok;
  assign inputs_ok  = sn.safety_sense_a & sn.safety_sense_b;
  assign lock_req_v = p2lock_v ? sn.solenoid_cmd : ~sn.solenoid_cmd;
  assign locked_v   = lock_drive & sn.guard_closed & sn.actuator_present;

  always_comb begin
    safe_v = 1'b0;
    diag_v = 1'b0;
    if (st_r == ISC_RUN && sn.guard_closed && sn.actuator_present) begin
      safe_v = (guardmon_v | locked_v) & inputs_ok & ~warn_trip;
      diag_v = (locked_v | ~lock_req_v) & ~sn.fault_warning;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_drive_a <= 1'b0;
      safe_drive_b <= 1'b0;
      diag_out     <= 1'b0;
      lock_drive   <= 1'b0;
    end else begin
      safe_drive_a <= safe_v;
      safe_drive_b <= safe_v;
      diag_out     <= diag_v;
      lock_drive   <= lock_req_v & sn.guard_closed & sn.handle_detent;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_green  <= 1'b0;
      led_yellow <= 1'b0;
      led_red    <= 1'b0;
    end else begin
      led_green  <= 1'b1;
      led_red    <= 1'b0;
      led_yellow <= locked_v ? 1'b1 : (sn.guard_closed & slow_r);
      case (st_r)
        ISC_TEACH_SHOW: begin
          led_green  <= 1'b0;
          led_red    <= 1'b1;
          led_yellow <= slow_r;
        end
        ISC_TEACH_OFFREQ: begin
          led_green  <= 1'b0;
          led_red    <= 1'b1;
          led_yellow <= fast_r;
        end
        ISC_TEACH_ABORT: begin
          led_yellow <= 1'b0;
          led_red    <= slow_r && pulse_cnt_r < 4'(ERR_PULSES);
        end
        ISC_INHIBIT: begin
          led_green  <= slow_r;
          led_yellow <= 1'b0;
        end
        ISC_ERROR: begin
          led_yellow <= 1'b0;
          led_red    <= slow_r;
        end
        default: begin
          if (sn.fault_warning) begin
            led_red <= slow_r;
          end else if (!inputs_ok) begin
            led_green <= slow_r;
          end
        end
      endcase
    end
  end

  // Read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL:   hrdata <= ctrl_r;
        ADDR_STATUS: hrdata <= {22'h0, warn_trip, sn.fault_warning, paired_r,
                                code_valid_r, learn_pend_r, inhibit_pend_r, 4'(st_r)};
        ADDR_CODE:   hrdata <= {16'h0, code_r};
        ADDR_SENSE:  hrdata <= {24'h0, filt_r};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  a_teach_outputs_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == ISC_TEACH_SHOW || st_r == ISC_INHIBIT) |=> (!safe_drive_a && !diag_out))
    else $error("safety output high during teach-in or inhibit");
  a_error_drops_safe: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == ISC_ERROR) |=> !safe_drive_a && !safe_drive_b)
    else $error("safety output high in error");
  a_detent_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    !sn.handle_detent |=> !lock_drive)
    else $error("locked outside detent");
  a_warn_diag_low: assert property (@(posedge hclk) disable iff (!hresetn)
    sn.fault_warning |=> !diag_out)
    else $error("diagnostic high during warning");
  a_warn_trip_off: assert property (@(posedge hclk) disable iff (!hresetn)
    warn_trip |=> !safe_drive_a)
    else $error("safety output on after warning timeout");
  a_teach_led: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_r == ISC_TEACH_SHOW) |=> !led_green && led_red)
    else $error("teach-in LED pattern wrong");
  a_perm_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    (perm_v && paired_r && st_r == ISC_RUN) |=> st_r != ISC_TEACH_SHOW)
    else $error("permanent variant re-entered teach-in");
  a_lock_monitor: assert property (@(posedge hclk) disable iff (!hresetn)
    (!guardmon_v && !lock_drive) |=> !safe_drive_a)
    else $error("lock-monitoring output high while unlocked");
endmodule : isc_controller

// File: testbench/isc_plc_model.sv
// Machine controller model: solenoid command and upstream safety chain
module isc_plc_model
  import isc_pkg::*;
(
  input  wire logic hclk,          // System clock
  input  wire logic hresetn,       // Reset, active low
  input  wire logic lock_req,      // Bench asks for the guard locked
  input  wire logic power_to_lock, // Polarity of the interlock
  input  wire logic slow,          // Answer eight cycles late
  input  wire logic chain_ok,      // Upstream guards closed
  output logic      solenoid_cmd,  // Solenoid command to interlock
  output logic      sense_a,       // Safety chain channel A
  output logic      sense_b        // Safety chain channel B
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] delay_r;
  logic       lock_sel;

  assign lock_sel = slow ? delay_r[7] : lock_req;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) delay_r <= 8'h00;
    else delay_r <= {delay_r[6:0], lock_req};
  end

  // Lock level follows the polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) solenoid_cmd <= 1'b0;
    else solenoid_cmd <= power_to_lock ? lock_sel : ~lock_sel;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_a <= 1'b0;
      sense_b <= 1'b0;
    end else begin
      sense_a <= chain_ok;
      sense_b <= chain_ok;
    end
  end
endmodule // isc_plc_model

// File: testbench/test_isc_controller.sv
// Self-checking bench of the interlock state controller
`define isc_chk(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module test_isc_controller
  import isc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic act = 1'b0, grd = 1'b0, det = 1'b1, lock_req = 1'b0, chain = 1'b1, flt = 1'b0, wrn = 1'b0;
  logic p2l = 1'b0, slow = 1'b0, sol, sa, sb, safe_a, safe_b, diag, lock, g, y, r;
  int errors = 0, num_checks = 0;

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  isc_controller isc_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .actuator_pin(act),
    .actuator_code(16'h5A3C), .guard_pin(grd), .detent_pin(det), .solenoid_pin(sol),
    .safety_sense_a(sa), .safety_sense_b(sb), .fault_pin(flt), .warn_pin(wrn),
    .safe_drive_a(safe_a), .safe_drive_b(safe_b), .diag_out(diag), .lock_drive(lock),
    .led_green(g), .led_yellow(y), .led_red(r));

  isc_plc_model isc_plc_model_i (.hclk(hclk), .hresetn(hresetn), .lock_req(lock_req),
    .power_to_lock(p2l), .slow(slow), .chain_ok(chain), .solenoid_cmd(sol), .sense_a(sa),
    .sense_b(sb));

  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask

  task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] d);
    logic [31:0] rd;
    ahb_xfer(1'b1, addr, d, rd);
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] addr, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] rd;
    ahb_xfer(1'b0, addr, 32'h00000000, rd);
    `isc_chk("hresp", 1'b0, hresp)
    `isc_chk(nm, exp, rd & mask)
  endtask

  // Drive the pins, then let the input filters and the controller settle
  task automatic set_env(input logic a, gd, dt, lk, ch, f, w);
    act <= a;
    grd <= gd;
    det <= dt;
    lock_req <= lk;
    chain <= ch;
    flt <= f;
    wrn <= w;
    repeat (24) @(posedge hclk);
  endtask

  task automatic power_cycle;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    test_done();
  end

  initial begin
    power_cycle();
    chk_rd("ctrl reset", ADDR_CTRL, 32'hFFFFFFFF, CTRL_RESET);
    reg_wr(ADDR_CTRL, 32'hFFFFFFFF);
    chk_rd("ctrl mask", ADDR_CTRL, 32'hFFFFFFFF, CTRL_MASK);
    chk_rd("unmapped", 8'h10, 32'hFFFFFFFF, 32'h00000000);
    reg_wr(ADDR_CTRL, 32'h00000000);
    set_env(1, 1, 1, 1, 1, 0, 0);
    chk_rd("state run", ADDR_STATUS, 32'h0000000F, 32'h00000000);
    `isc_chk("locked", 4'hF, {safe_a, safe_b, diag, lock})
    `isc_chk("leds locked", 3'h6, {g, y, r})
    set_env(1, 1, 1, 0, 1, 0, 0);
    `isc_chk("unlocked", 4'h2, {safe_a, safe_b, diag, lock})
    set_env(1, 1, 1, 1, 1, 0, 0);
    `isc_chk("relocked", 4'hF, {safe_a, safe_b, diag, lock})
    reg_wr(ADDR_CTRL, 32'h00000004);
    p2l <= 1'b1;
    slow <= 1'b1;
    set_env(1, 1, 1, 1, 1, 0, 0);
    `isc_chk("p2l locked", 4'hF, {safe_a, safe_b, diag, lock})
    set_env(1, 1, 1, 0, 1, 0, 0);
    `isc_chk("p2l unlocked", 4'h2, {safe_a, safe_b, diag, lock})
    reg_wr(ADDR_CTRL, 32'h0000000C);
    repeat (4) @(posedge hclk);
    `isc_chk("guard mon closed", 4'hE, {safe_a, safe_b, diag, lock})
    set_env(0, 0, 1, 0, 1, 0, 0);
    `isc_chk("guard open", 4'h0, {safe_a, safe_b, diag, lock})
    reg_wr(ADDR_CTRL, 32'h00000000);
    p2l <= 1'b0;
    slow <= 1'b0;
    set_env(1, 1, 0, 1, 1, 0, 0);
    `isc_chk("between detents", 4'h0, {safe_a, safe_b, diag, lock})
    set_env(1, 1, 1, 1, 0, 0, 0);
    `isc_chk("chain open", 4'h1, {safe_a, safe_b, r, y})
    set_env(1, 1, 1, 1, 1, 0, 1);
    `isc_chk("warning", 4'hD, {safe_a, safe_b, diag, lock})
    chk_rd("warn flag", ADDR_STATUS, 32'h00000100, 32'h00000100);
    set_env(1, 1, 1, 1, 1, 0, 0);
    `isc_chk("warn gone", 4'hF, {safe_a, safe_b, diag, lock})
    set_env(1, 1, 1, 1, 1, 1, 0);
    `isc_chk("error", 4'h0, {safe_a, safe_b, diag, y})
    chk_rd("state error", ADDR_STATUS, 32'h0000000F, 32'h00000006);
    set_env(1, 1, 1, 1, 1, 0, 0);
    `isc_chk("error held", 3'h0, {safe_a, safe_b, diag})
    set_env(0, 0, 1, 0, 1, 0, 0);
    set_env(1, 1, 1, 1, 1, 0, 0);
    `isc_chk("error cleared", 4'hF, {safe_a, safe_b, diag, lock})
    set_env(0, 0, 1, 0, 1, 0, 0);
    power_cycle();
    reg_wr(ADDR_CTRL, 32'h00000010);
    set_env(1, 1, 1, 1, 1, 0, 0);
    chk_rd("state teach", ADDR_STATUS, 32'h0000000F, 32'h00000001);
    `isc_chk("teach outputs", 3'h0, {safe_a, safe_b, diag})
    `isc_chk("teach leds", 2'h1, {g, r})
    test_done();
  end
endmodule // test_isc_controller
